/* File: verilog/bpc_top.sv */
// Bus pin control block: memory strobes, upper lane enable, interrupt pin
// and reset levels of the bus interface pins.
// Assumes the DMA engine supplies cycle requests synchronous to ref_clk and
// that the host keeps to the chip select protocol while the device is slave.
`timescale 1ns/100ps
`default_nettype none

module bpc_top
  import bpc_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     sys_rst,
  // Bus ownership and mode
  input  wire logic     bus_master,
  input  wire logic     width_sel,
  // DMA cycle request
  input  wire bpc_cyc_t dma_cycle,
  input  wire logic     dma_addr0,
  input  wire logic     dma_both_lanes,
  // Interrupt control
  input  wire logic     irq_event,
  input  wire logic     irq_clear_in,
  // Host slave strobes
  input  wire logic     chip_sel_n,
  input  wire logic     io_read_strobe_n,
  input  wire logic     io_write_strobe_n,
  // Other core outputs, applied after reset
  input  wire logic     hold_req_in,
  input  wire logic     addr_latch_strobe_in,
  input  wire logic     aen_in,
  input  wire logic     txd_in,
  input  wire logic [2:0] gp_in,
  // Memory strobes
  output logic          mem_read_strobe_n,
  output logic          mem_read_oe,
  output logic          mem_write_strobe_n,
  output logic          mem_write_oe,
  // Upper lane enable
  output logic          upper_lane_enable_n,
  output logic          upper_lane_oe,
  // Host interface
  output logic          irq_out,
  output logic          host_rd_req,
  output logic          host_wr_req,
  // Fixed reset-level outputs
  output logic          bus_hold_request,
  output logic          addr_latch_strobe,
  output logic          addr_drive_enable,
  output logic          serial_tx_data,
  output logic          gp_out_1,
  output logic          gp_out_2,
  output logic          gp_out_3,
  output logic          bus_float_oe
);

  // ==========================================================
  // Reset sampling
  // ==========================================================
  logic core_rst;

  // Reset goes through the clocked latch before reaching the pins.
  bpc_rst_latch #(
    .STAGES (RST_SYNC_STAGES)
  ) u_rst (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .core_rst (core_rst)
  );

  // ==========================================================
  // Strobe and lane logic
  // ==========================================================
  logic rd_n_reg, rd_n_next, rd_oe_reg, rd_oe_next;
  logic wr_n_reg, wr_n_next, wr_oe_reg, wr_oe_next;
  logic ube_n_reg, ube_n_next, ube_oe_reg, ube_oe_next;

  // Strobes drive only as master; lane enable only in word mode.
  always_comb begin
    rd_oe_next  = bus_master;
    wr_oe_next  = bus_master;
    rd_n_next   = !(bus_master && dma_cycle == BPC_READ);
    wr_n_next   = !(bus_master && dma_cycle == BPC_WRITE);
    ube_oe_next = bus_master && (width_sel == WIDTH_WORD);
    // Upper lane active when both lanes or an odd address.
    ube_n_next  = !(dma_both_lanes || dma_addr0);
    if (dma_both_lanes) begin
      ube_n_next = 1'h0;
    end
  end

  // Registers the strobe pins; reset floats them.
  always_ff @(posedge ref_clk or posedge core_rst) begin
    if (core_rst) begin
      rd_n_reg   <= 1'h1;
      wr_n_reg   <= 1'h1;
      ube_n_reg  <= 1'h1;
      rd_oe_reg  <= RST_OE_LVL;
      wr_oe_reg  <= RST_OE_LVL;
      ube_oe_reg <= RST_OE_LVL;
    end else begin
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      ube_n_reg  <= ube_n_next;
      rd_oe_reg  <= rd_oe_next;
      wr_oe_reg  <= wr_oe_next;
      ube_oe_reg <= ube_oe_next;
    end
  end

  // ==========================================================
  // Interrupt and host strobes
  // ==========================================================
  logic irq_reg, irq_next, clr_d_reg, clr_d_next;
  logic hrd_reg, hrd_next, hwr_reg, hwr_next;

  // A new event wins over a clear edge in the same cycle.
  always_comb begin
    clr_d_next = irq_clear_in;
    irq_next   = irq_reg;
    if (irq_clear_in && !clr_d_reg) begin
      irq_next = 1'h0;
    end
    if (irq_event) begin
      irq_next = 1'h1;
    end
    // Host strobes are honoured only while the device is slave.
    hrd_next = !bus_master && !chip_sel_n && !io_read_strobe_n;
    hwr_next = !bus_master && !chip_sel_n && !io_write_strobe_n;
  end

  // Registers interrupt state and host access requests.
  always_ff @(posedge ref_clk or posedge core_rst) begin
    if (core_rst) begin
      irq_reg   <= RST_IRQ_LVL;
      clr_d_reg <= 1'h0;
      hrd_reg   <= 1'h0;
      hwr_reg   <= 1'h0;
    end else begin
      irq_reg   <= irq_next;
      clr_d_reg <= clr_d_next;
      hrd_reg   <= hrd_next;
      hwr_reg   <= hwr_next;
    end
  end

  // ==========================================================
  // Fixed-level outputs
  // ==========================================================
  logic       hold_reg, hold_next, addr_latch_strobe_reg, addr_latch_strobe_next;
  logic       aen_reg, aen_next, txd_reg, txd_next;
  logic [2:0] gp_reg, gp_next;
  logic       float_reg, float_next;

  // After reset the core's own values take over the pins.
  always_comb begin
    hold_next  = hold_req_in;
    addr_latch_strobe_next  = addr_latch_strobe_in;
    aen_next   = aen_in;
    txd_next   = txd_in;
    gp_next    = gp_in;
    float_next = bus_master;
  end

  // Reset forces documented levels; they stand until the core changes them.
  always_ff @(posedge ref_clk or posedge core_rst) begin
    if (core_rst) begin
      hold_reg  <= RST_HOLD_LVL;
      addr_latch_strobe_reg  <= RST_ADDR_LATCH_STROBE_LVL;
      aen_reg   <= RST_AEN_LVL;
      txd_reg   <= RST_TXD_LVL;
      gp_reg    <= {3{RST_GP_LVL}};
      float_reg <= RST_OE_LVL;
    end else begin
      hold_reg  <= hold_next;
      addr_latch_strobe_reg  <= addr_latch_strobe_next;
      aen_reg   <= aen_next;
      txd_reg   <= txd_next;
      gp_reg    <= gp_next;
      float_reg <= float_next;
    end
  end

  // Outputs straight from the flip-flops.
  assign mem_read_strobe_n   = rd_n_reg;
  assign mem_read_oe         = rd_oe_reg;
  assign mem_write_strobe_n  = wr_n_reg;
  assign mem_write_oe        = wr_oe_reg;
  assign upper_lane_enable_n = ube_n_reg;
  assign upper_lane_oe       = ube_oe_reg;
  assign irq_out             = irq_reg;
  assign host_rd_req         = hrd_reg;
  assign host_wr_req         = hwr_reg;
  assign bus_hold_request    = hold_reg;
  assign addr_latch_strobe   = addr_latch_strobe_reg;
  assign addr_drive_enable   = aen_reg;
  assign serial_tx_data      = txd_reg;
  assign gp_out_1            = gp_reg[0];
  assign gp_out_2            = gp_reg[1];
  assign gp_out_3            = gp_reg[2];
  assign bus_float_oe        = float_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  // The sampled core reset in an antecedent skips the edge at which reset
  // lifts: the pins were still held then, so a request there is not taken.
  a_read_strobe: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    (!core_rst && bus_master && dma_cycle == BPC_READ) |=>
    !mem_read_strobe_n)
    else $error("read strobe not low in master read");
  a_write_float: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    !bus_master |=> !mem_write_oe && mem_write_strobe_n)
    else $error("write strobe driven while slave");
  a_byte_float: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    (width_sel == WIDTH_BYTE) |=> !upper_lane_oe)
    else $error("upper lane driven in byte mode");
  a_word_drive: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    (!core_rst && bus_master && width_sel == WIDTH_WORD) |=> upper_lane_oe)
    else $error("upper lane not driven in word mode");
  a_lane_code: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    (!dma_both_lanes && !dma_addr0) |=> upper_lane_enable_n)
    else $error("lower-only lane code wrong");
  a_irq_raise: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    (!core_rst && irq_event) |=> irq_out)
    else $error("interrupt not raised");
  a_irq_clear: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    ($rose(irq_clear_in) && !irq_event) |=> !irq_out)
    else $error("interrupt not cleared on edge");
  a_rst_levels: assert property (
    @(posedge ref_clk)
    sys_rst [*4] |-> !irq_out && gp_out_1 && !mem_read_oe)
    else $error("reset levels not reached in four clocks");
  a_hold_keep: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    $fell(core_rst) |-> !bus_hold_request && serial_tx_data)
    else $error("reset levels lost at release");
  a_host_gate: assert property (
    @(posedge ref_clk) disable iff (core_rst)
    bus_master |=> !host_rd_req && !host_wr_req)
    else $error("host access taken while master");

endmodule

`default_nettype wire

/* File: verilog/bpc_pkg.sv */
// Package for the bus pin control block.
// Assumes a single 20 MHz system clock and no software registers.
`default_nettype none

package bpc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RST_LATCH_CLKS = 4;
  localparam int unsigned RST_SYNC_STAGES = RST_LATCH_CLKS - 1;

  // ==========================================================
  // Reset levels of the driven outputs
  // ==========================================================
  localparam logic RST_IRQ_LVL = 1'h0;
  localparam logic RST_HOLD_LVL = 1'h0;
  localparam logic RST_ADDR_LATCH_STROBE_LVL = 1'h0;
  localparam logic RST_AEN_LVL = 1'h0;
  localparam logic RST_TXD_LVL = 1'h1;
  localparam logic RST_GP_LVL = 1'h1;
  localparam logic RST_OE_LVL = 1'h0;

  // ==========================================================
  // Transfer width select
  // ==========================================================
  localparam logic WIDTH_BYTE = 1'h0;
  localparam logic WIDTH_WORD = 1'h1;

  // Bus cycle kinds requested by the internal DMA engine.
  typedef enum logic [1:0] {
    BPC_IDLE  = 2'b00,
    BPC_READ  = 2'b01,
    BPC_WRITE = 2'b10
  } bpc_cyc_t;

endpackage

`default_nettype wire

/* File: verilog/bpc_rst_latch.sv */
// Reset latch for the bus pin control block.
// Assumes sys_rst is asynchronous and ref_clk runs freely.
`timescale 1ns/100ps
`default_nettype none

module bpc_rst_latch
  import bpc_pkg::*;
#(
  parameter int unsigned STAGES = RST_SYNC_STAGES
) (
  // Clock and raw reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Reset as seen by the core
  output logic      core_rst
);

  // ==========================================================
  // Sampling chain
  // ==========================================================
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;

  // Shift ones in while reset is high; chain output is the core reset.
  always_comb begin
    chain_next = {chain_reg[STAGES-2:0], sys_rst};
  end

  // Registers the chain; reset fills it at once, so the core reset rises
  // without waiting for the clock and drops only after the chain drains.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_reg <= '1;
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign core_rst = chain_reg[STAGES-1];

endmodule

`default_nettype wire

/* File: verif/bpc_host_model.sv */
// Host processor model for the bus pin control block.
// Assumes the bench raises the go levels just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module bpc_host_model (
  // Clock and bench requests
  input  wire logic ref_clk,
  input  wire logic clr_go,
  input  wire logic rd_go,
  input  wire logic wr_go,
  // Host pins toward the block
  output var logic  irq_clear_in,
  output var logic  chip_sel_n,
  output var logic  io_read_strobe_n,
  output var logic  io_write_strobe_n
);
  // ==========================================================
  // Host pins
  // ==========================================================
  // Pins change only after a rising edge and hold for whole cycles; they
  // settle to idle at the first edge, long before reset is released.
  always @(posedge ref_clk) begin
    irq_clear_in <= clr_go;
    chip_sel_n <= ~(rd_go | wr_go);
    io_read_strobe_n <= ~rd_go;
    io_write_strobe_n <= ~wr_go;
  end
endmodule
`default_nettype wire

/* File: verif/test_bus_pin_control_and_reset_state.sv */
// Self-checking bench for the bus pin control block.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_bus_pin_control_and_reset_state
  import bpc_pkg::*;
;
  // ==========================================================
  // Signals
  // ==========================================================
  logic ref_clk = 1'b0, sys_rst = 1'b1, bus_master = 1'b0, width_sel = 1'b0;
  bpc_cyc_t dma_cycle = BPC_IDLE;
  logic dma_addr0 = 1'b0, dma_both_lanes = 1'b0, irq_event = 1'b0;
  logic hold_req_in = 1'b0, addr_latch_strobe_in = 1'b0, aen_in = 1'b0, txd_in = 1'b1;
  logic [2:0] gp_in = 3'h7;
  logic clr_go = 1'b0, rd_go = 1'b0, wr_go = 1'b0;
  logic irq_clear_in, chip_sel_n, io_read_strobe_n, io_write_strobe_n;
  logic mem_read_strobe_n, mem_read_oe, mem_write_strobe_n, mem_write_oe;
  logic upper_lane_enable_n, upper_lane_oe, irq_out, host_rd_req;
  logic host_wr_req, bus_hold_request, addr_latch_strobe, addr_drive_enable;
  logic serial_tx_data, gp_out_1, gp_out_2, gp_out_3, bus_float_oe;
  int errors = 0, n_checks = 0, cycles = 0;

  // Clock at 20 MHz.
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  bpc_host_model bpc_host_model_inst (.ref_clk, .clr_go, .rd_go, .wr_go,
    .irq_clear_in, .chip_sel_n, .io_read_strobe_n, .io_write_strobe_n);

  bpc_top bpc_top_inst (.ref_clk, .sys_rst, .bus_master, .width_sel,
    .dma_cycle, .dma_addr0, .dma_both_lanes, .irq_event, .irq_clear_in,
    .chip_sel_n, .io_read_strobe_n, .io_write_strobe_n, .hold_req_in,
    .addr_latch_strobe_in, .aen_in, .txd_in, .gp_in, .mem_read_strobe_n, .mem_read_oe,
    .mem_write_strobe_n, .mem_write_oe, .upper_lane_enable_n,
    .upper_lane_oe, .irq_out, .host_rd_req, .host_wr_req, .bus_hold_request,
    .addr_latch_strobe, .addr_drive_enable, .serial_tx_data, .gp_out_1,
    .gp_out_2, .gp_out_3, .bus_float_oe);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Compares one pin against its expected level.
  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Lets n edges pass and stops mid-cycle where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Checks every output enable, irq_out and the fixed-level pins against their reset levels.
  task automatic chk_rst();
    chk("mem_read_oe", RST_OE_LVL, mem_read_oe);
    chk("mem_write_oe", RST_OE_LVL, mem_write_oe);
    chk("upper_lane_oe", RST_OE_LVL, upper_lane_oe);
    chk("bus_float_oe", RST_OE_LVL, bus_float_oe);
    chk("irq_out", RST_IRQ_LVL, irq_out);
    chk("bus_hold_request", RST_HOLD_LVL, bus_hold_request);
    chk("addr_latch_strobe", RST_ADDR_LATCH_STROBE_LVL, addr_latch_strobe);
    chk("addr_drive_enable", RST_AEN_LVL, addr_drive_enable);
    chk("serial_tx_data", RST_TXD_LVL, serial_tx_data);
    chk("gp_out_1", RST_GP_LVL, gp_out_1);
    chk("gp_out_2", RST_GP_LVL, gp_out_2);
    chk("gp_out_3", RST_GP_LVL, gp_out_3);
  endtask

  // Closing report; the only place the run ends.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Reset in mid-run with every core value but upper_lane_oe opposite to its reset level.
  task automatic t_reset();
    @(posedge ref_clk);
    bus_master <= 1'b1;
    dma_cycle <= BPC_READ;
    {hold_req_in, addr_latch_strobe_in, aen_in, txd_in, gp_in} <= 7'h70;
    // Core values stay opposite to reset levels until after release.
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    sys_rst <= 1'b1;
    settle(4);
    chk_rst();
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle(2);
    chk_rst();
    @(posedge ref_clk);
    bus_master <= 1'b0;
    dma_cycle <= BPC_IDLE;
    {hold_req_in, addr_latch_strobe_in, aen_in, txd_in, gp_in} <= 7'h0F;
    settle(6);
    chk_rst();
    $display("t_reset done");
  endtask

  // Master read, master write, then slave release of both strobes.
  task automatic t_master();
    @(posedge ref_clk);
    bus_master <= 1'b1;
    dma_cycle <= BPC_READ;
    settle(2);
    chk("mem_read_oe", 1'b1, mem_read_oe);
    chk("bus_float_oe", 1'b1, bus_float_oe);
    chk("mem_read_strobe_n", 1'b0, mem_read_strobe_n);
    @(posedge ref_clk);
    dma_cycle <= BPC_WRITE;
    settle(2);
    chk("mem_write_oe", 1'b1, mem_write_oe);
    chk("mem_write_strobe_n", 1'b0, mem_write_strobe_n);
    chk("mem_read_strobe_n", 1'b1, mem_read_strobe_n);
    @(posedge ref_clk);
    bus_master <= 1'b0;
    settle(2);
    chk("mem_write_oe", 1'b0, mem_write_oe);
    chk("mem_read_oe", 1'b0, mem_read_oe);
    $display("t_master done");
  endtask

  // Byte mode floats the lane pin; word mode walks all three encodings.
  task automatic t_lanes();
    @(posedge ref_clk);
    bus_master <= 1'b1;
    dma_cycle <= BPC_READ;
    width_sel <= WIDTH_BYTE;
    dma_both_lanes <= 1'b1;
    settle(2);
    chk("upper_lane_oe", 1'b0, upper_lane_oe);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      width_sel <= WIDTH_WORD;
      dma_both_lanes <= (i == 0);
      dma_addr0 <= (i == 1);
      settle(2);
      chk("upper_lane_oe", 1'b1, upper_lane_oe);
      chk("upper_lane_enable_n", i == 2, upper_lane_enable_n);
    end
    @(posedge ref_clk);
    bus_master <= 1'b0;
    dma_cycle <= BPC_IDLE;
    width_sel <= WIDTH_BYTE;
    $display("t_lanes done");
  endtask

  // Interrupt raised by an event, held, then dropped by a clear edge.
  task automatic t_irq();
    @(posedge ref_clk);
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    settle(3);
    chk("irq_out", 1'b1, irq_out);
    @(posedge ref_clk);
    clr_go <= 1'b1;
    settle(3);
    chk("irq_out", 1'b0, irq_out);
    // A new event while the clear input stays high must not be dropped.
    @(posedge ref_clk);
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    settle(2);
    chk("irq_out", 1'b1, irq_out);
    @(posedge ref_clk);
    clr_go <= 1'b0;
    $display("t_irq done");
  endtask

  // Host read strobe refused while master; read and write strobes taken while slave.
  task automatic t_host();
    @(posedge ref_clk);
    {bus_master, rd_go} <= 2'b11;
    settle(3);
    chk("host_rd_req", 1'b0, host_rd_req);
    @(posedge ref_clk);
    bus_master <= 1'b0;
    settle(2);
    chk("host_rd_req", 1'b1, host_rd_req);
    @(posedge ref_clk);
    {rd_go, wr_go} <= 2'b01;
    settle(3);
    chk("host_wr_req", 1'b1, host_wr_req);
    chk("host_rd_req", 1'b0, host_rd_req);
    @(posedge ref_clk);
    wr_go <= 1'b0;
    $display("t_host done");
  endtask

  // Cuts a hang short well past the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle(6);
    t_reset();
    t_master();
    t_lanes();
    t_irq();
    t_host();
    end_of_test();
  end
endmodule
`default_nettype wire
